// *** spr_defines.vh ***
// constants for the strap and pin routing block
`ifndef SPR_DEFINES_VH
`define SPR_DEFINES_VH

// ****************************************
// register map
// ****************************************
`define SPR_ADDR_W 4
`define SPR_ADDR_CTRL 4'h0
`define SPR_ADDR_STATUS 4'h4
`define SPR_ADDR_GPIO 4'h8
`define SPR_RESP_OKAY 2'h0
`define SPR_RESP_SLVERR 2'h2

// ****************************************
// control fields and reset values
// ****************************************
`define SPR_CTRL_REROUTE 0
`define SPR_CTRL_MASTER 1
`define SPR_CTRL_G0_ALERT 2
`define SPR_CTRL_CR_PUSHPULL 3
`define SPR_CTRL_WL_PD_OFF 4
`define SPR_CTRL_BT_PD_OFF 5
`define SPR_CTRL_RESET 8'h00
`define SPR_GPIO_OUT 0
`define SPR_GPIO_OE 1
`define SPR_GPIO_RESET 8'h00
`define SPR_STRAP_DEFAULT 1'b1

// ****************************************
// timing
// ****************************************
`define SPR_CLK_MHZ 200
`define SPR_STRAP_DELAY_US 2000
`define SPR_STRAP_CYCLES (`SPR_STRAP_DELAY_US * `SPR_CLK_MHZ)
`define SPR_SLEEP_CLK_HZ 32768
`define SPR_SLEEP_MISS_PERIODS 4
`define SPR_SLEEP_MISS_CYCLES (`SPR_SLEEP_MISS_PERIODS * `SPR_CLK_MHZ * 1000000 / `SPR_SLEEP_CLK_HZ)

`endif

// *** spr_strap_latch.v ***
// power-on strap sampler for the host interface select
`timescale 1ns/1ps
`include "spr_defines.vh"
module spr_strap_latch #(
    parameter DELAY_CYCLES = `SPR_STRAP_CYCLES
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // strap pin
    input wire strap_in,
    // latched result
    output reg done_r,
    output reg generic_mode_r
);
    localparam CW = $clog2(DELAY_CYCLES + 1);
    localparam integer LAST_I = DELAY_CYCLES - 1;
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];

    reg [CW-1:0] cnt_r;

    // wait out the settle time, sample once, then hold until next reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= {CW{1'b0}};
            done_r <= 1'b0;
            generic_mode_r <= ~`SPR_STRAP_DEFAULT;
        end else if (!done_r) begin
            if (cnt_r == LAST) begin
                done_r <= 1'b1;
                generic_mode_r <= ~strap_in;
            end else begin
                cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
            end
        end
        // done_r never falls again, so the result is frozen
    end
endmodule

// *** spr_sleep_clk_mon.v ***
// presence monitor for the external sleep clock
`timescale 1ns/1ps
`include "spr_defines.vh"
module spr_sleep_clk_mon #(
    parameter MISS_CYCLES = `SPR_SLEEP_MISS_CYCLES
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // sleep clock pin, sampled as a plain input
    input wire sleep_clock_in,
    // presence flag
    output reg present_r
);
    localparam CW = $clog2(MISS_CYCLES + 1);
    localparam integer LAST_I = MISS_CYCLES - 1;
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];

    reg prev_r;
    reg [CW-1:0] gap_r;

    // a rising edge proves the clock; a long gap without one means the pin is stuck low or high
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= 1'b0;
            gap_r <= {CW{1'b0}};
            present_r <= 1'b0;
        end else begin
            prev_r <= sleep_clock_in;
            if (sleep_clock_in && !prev_r) begin
                gap_r <= {CW{1'b0}};
                present_r <= 1'b1;
            end else if (gap_r == LAST) begin
                present_r <= 1'b0;
            end else begin
                gap_r <= gap_r + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// *** spr_pin_router.v ***
// pin function routing, strap capture, power enables and clock request
`timescale 1ns/1ps
`include "spr_defines.vh"
module spr_pin_router #(
    parameter STRAP_DELAY_CYCLES = `SPR_STRAP_CYCLES,
    parameter SLEEP_MISS_CYCLES = `SPR_SLEEP_MISS_CYCLES
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite register slave
    input wire [`SPR_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`SPR_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // strap, enables and sleep clock pins
    input wire host_if_strap,
    input wire wlan_power_enable,
    input wire bluetooth_power_enable,
    input wire sleep_clock_in,
    // link uart and wake pins
    input wire link_serial_in,
    output reg link_serial_out,
    input wire link_clear_to_send_n_i,
    output reg link_clear_to_send_n_o,
    output reg link_clear_to_send_n_oe_n,
    input wire link_request_to_send_n_i,
    output reg link_request_to_send_n_o,
    output reg link_request_to_send_n_oe_n,
    input wire host_alert_pin_i,
    output reg host_alert_pin_o,
    output reg host_alert_pin_oe_n,
    input wire device_wake_pin_i,
    output reg device_wake_pin_o,
    output reg device_wake_pin_oe_n,
    // dedicated voice pins
    input wire voice_clk_pin_i,
    output reg voice_clk_pin_o,
    output reg voice_clk_pin_oe_n,
    input wire voice_sync_pin_i,
    output reg voice_sync_pin_o,
    output reg voice_sync_pin_oe_n,
    input wire voice_in_pin,
    output reg voice_out_pin,
    // clock request and gpio zero pins
    input wire clk_req_pin_i,
    output reg clk_req_pin_o,
    output reg clk_req_pin_oe_n,
    input wire gpio0_pin_i,
    output reg gpio0_pin_o,
    output reg gpio0_pin_oe_n,
    // bluetooth section side
    input wire bt_serial_out,
    input wire bt_rts_n,
    input wire host_alert_pin,
    input wire host_alert_pin_en,
    input wire bt_voice_clk,
    input wire bt_voice_sync,
    input wire bt_voice_dout,
    input wire bt_clk_need,
    output reg bt_serial_in,
    output reg bt_cts_n,
    output reg device_wake_pin,
    output reg bt_voice_clk_in,
    output reg bt_voice_sync_in,
    output reg bt_voice_din,
    output reg bt_three_wire,
    output reg bt_voice_master,
    output reg bt_regulator_on,
    output reg bt_reset_n,
    output reg ble_deep_sleep_ok,
    // wlan section side
    input wire wlan_clk_need,
    input wire wlan_host_alert,
    output reg wlan_regulator_on,
    output reg wlan_reset_n,
    output reg wlan_generic_serial_host_mode,
    output reg wlan_strap_done,
    // pad pull-down controls
    output reg wlan_enable_pulldown_on,
    output reg bt_enable_pulldown_on
);
    // ****************************************
    // state and helpers
    // ****************************************
    reg [7:0] ctrl_r;
    reg [7:0] gpio_r;
    reg [`SPR_ADDR_W-1:0] awaddr_r;
    reg [7:0] wdata_r;
    reg wstrb0_r;
    wire strap_done;
    wire strap_generic;
    wire sleep_ok;
    wire [7:0] status_w;
    wire reroute;
    wire master;
    wire clk_need;

    // only three aligned words are mapped
    function addr_ok;
        input [`SPR_ADDR_W-1:0] a;
        begin
            addr_ok = (a == `SPR_ADDR_CTRL) || (a == `SPR_ADDR_STATUS) ||
                      (a == `SPR_ADDR_GPIO);
        end
    endfunction

    // read mux; all registers sit in the low byte
    function [31:0] rd_word;
        input [`SPR_ADDR_W-1:0] a;
        input [7:0] c;
        input [7:0] s;
        input [7:0] g;
        begin
            case (a)
                `SPR_ADDR_CTRL: rd_word = {24'h000000, c};
                `SPR_ADDR_STATUS: rd_word = {24'h000000, s};
                `SPR_ADDR_GPIO: rd_word = {24'h000000, g};
                default: rd_word = 32'h00000000;
            endcase
        end
    endfunction

    assign reroute = ctrl_r[`SPR_CTRL_REROUTE];
    assign master = ctrl_r[`SPR_CTRL_MASTER];
    assign clk_need = wlan_clk_need | bt_clk_need;
    assign status_w = {1'b0, clk_req_pin_i, ~bt_reset_n, ~wlan_reset_n,
                       ble_deep_sleep_ok, gpio0_pin_i, wlan_strap_done,
                       wlan_generic_serial_host_mode};

    // ****************************************
    // strap capture and sleep clock
    // ****************************************
    spr_strap_latch #(
        .DELAY_CYCLES(STRAP_DELAY_CYCLES)
    ) u_strap (
        .aclk(aclk),
        .aresetn(aresetn),
        .strap_in(host_if_strap),
        .done_r(strap_done),
        .generic_mode_r(strap_generic)
    );

    spr_sleep_clk_mon #(
        .MISS_CYCLES(SLEEP_MISS_CYCLES)
    ) u_sleep (
        .aclk(aclk),
        .aresetn(aresetn),
        .sleep_clock_in(sleep_clock_in),
        .present_r(sleep_ok)
    );

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    // address and data are taken in either order; response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPR_RESP_OKAY;
            awaddr_r <= {`SPR_ADDR_W{1'b0}};
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
            ctrl_r <= `SPR_CTRL_RESET;
            gpio_r <= `SPR_GPIO_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(awaddr_r) ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
                // status is read only; a write there is accepted and dropped
                if (wstrb0_r && awaddr_r == `SPR_ADDR_CTRL) begin
                    ctrl_r <= wdata_r;
                end
                if (wstrb0_r && awaddr_r == `SPR_ADDR_GPIO) begin
                    gpio_r <= wdata_r;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    // one read at a time, data one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word(s_axi_araddr, ctrl_r, status_w, gpio_r);
            s_axi_rresp <= addr_ok(s_axi_araddr) ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // power, reset, strap and sleep outputs
    // ****************************************
    // wlan also waits for the strap so its host port never starts in the wrong mode
    always @(posedge aclk) begin
        if (!aresetn) begin
            wlan_regulator_on <= 1'b0;
            wlan_reset_n <= 1'b0;
            bt_regulator_on <= 1'b0;
            bt_reset_n <= 1'b0;
            wlan_enable_pulldown_on <= 1'b1;
            bt_enable_pulldown_on <= 1'b1;
            wlan_generic_serial_host_mode <= ~`SPR_STRAP_DEFAULT;
            wlan_strap_done <= 1'b0;
            ble_deep_sleep_ok <= 1'b0;
        end else begin
            wlan_regulator_on <= wlan_power_enable;
            wlan_reset_n <= wlan_power_enable & strap_done;
            bt_regulator_on <= bluetooth_power_enable;
            bt_reset_n <= bluetooth_power_enable;
            wlan_enable_pulldown_on <= ~ctrl_r[`SPR_CTRL_WL_PD_OFF];
            bt_enable_pulldown_on <= ~ctrl_r[`SPR_CTRL_BT_PD_OFF];
            wlan_generic_serial_host_mode <= strap_generic;
            wlan_strap_done <= strap_done;
            ble_deep_sleep_ok <= sleep_ok;
        end
    end

    // ****************************************
    // clock request and gpio zero
    // ****************************************
    // open drain unless the push-pull bit is set: pull low when idle, release so the board pull-up shows the request
    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_req_pin_o <= 1'b0;
            clk_req_pin_oe_n <= 1'b0;
            gpio0_pin_o <= 1'b0;
            gpio0_pin_oe_n <= 1'b1;
        end else begin
            if (ctrl_r[`SPR_CTRL_CR_PUSHPULL]) begin
                clk_req_pin_o <= clk_need;
                clk_req_pin_oe_n <= 1'b0;
            end else begin
                clk_req_pin_o <= 1'b0;
                clk_req_pin_oe_n <= clk_need;
            end
            if (ctrl_r[`SPR_CTRL_G0_ALERT]) begin
                gpio0_pin_o <= wlan_host_alert;
                gpio0_pin_oe_n <= 1'b0;
            end else begin
                gpio0_pin_o <= gpio_r[`SPR_GPIO_OUT];
                gpio0_pin_oe_n <= ~gpio_r[`SPR_GPIO_OE];
            end
        end
    end

    // ****************************************
    // link, wake and voice routing
    // ****************************************
    // every pin and every bluetooth-side signal is registered, one cycle of delay
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_serial_out <= 1'b1;
            link_request_to_send_n_o <= 1'b1;
            link_request_to_send_n_oe_n <= 1'b0;
            link_clear_to_send_n_o <= 1'b1;
            link_clear_to_send_n_oe_n <= 1'b1;
            host_alert_pin_o <= 1'b0;
            host_alert_pin_oe_n <= 1'b1;
            device_wake_pin_o <= 1'b0;
            device_wake_pin_oe_n <= 1'b1;
            voice_clk_pin_o <= 1'b0;
            voice_clk_pin_oe_n <= 1'b1;
            voice_sync_pin_o <= 1'b0;
            voice_sync_pin_oe_n <= 1'b1;
            voice_out_pin <= 1'b0;
            bt_serial_in <= 1'b1;
            bt_cts_n <= 1'b1;
            device_wake_pin <= 1'b0;
            bt_voice_clk_in <= 1'b0;
            bt_voice_sync_in <= 1'b0;
            bt_voice_din <= 1'b0;
            bt_three_wire <= 1'b0;
            bt_voice_master <= 1'b0;
        end else begin
            // serial lines keep their function in both modes
            link_serial_out <= bt_serial_out;
            bt_serial_in <= link_serial_in;
            bt_three_wire <= reroute;
            bt_voice_master <= master;
            device_wake_pin_o <= 1'b0;
            device_wake_pin_oe_n <= 1'b1;
            if (reroute) begin
                // voice on the link pins; flow control is gone, so cts reads clear
                link_request_to_send_n_o <= bt_voice_clk;
                link_request_to_send_n_oe_n <= ~master;
                link_clear_to_send_n_o <= bt_voice_dout;
                link_clear_to_send_n_oe_n <= 1'b0;
                host_alert_pin_o <= bt_voice_sync;
                host_alert_pin_oe_n <= ~master;
                bt_cts_n <= 1'b0;
                device_wake_pin <= 1'b0;
                bt_voice_din <= device_wake_pin_i;
                bt_voice_clk_in <= master ? bt_voice_clk : link_request_to_send_n_i;
                bt_voice_sync_in <= master ? bt_voice_sync : host_alert_pin_i;
                // dedicated voice clock and sync pins are released and voice out is held low while rerouted
                voice_clk_pin_o <= 1'b0;
                voice_clk_pin_oe_n <= 1'b1;
                voice_sync_pin_o <= 1'b0;
                voice_sync_pin_oe_n <= 1'b1;
                voice_out_pin <= 1'b0;
            end else begin
                // active-low flow control: rts driven out, cts taken in
                link_request_to_send_n_o <= bt_rts_n;
                link_request_to_send_n_oe_n <= 1'b0;
                link_clear_to_send_n_o <= 1'b1;
                link_clear_to_send_n_oe_n <= 1'b1;
                bt_cts_n <= link_clear_to_send_n_i;
                host_alert_pin_o <= host_alert_pin;
                host_alert_pin_oe_n <= ~host_alert_pin_en;
                device_wake_pin <= device_wake_pin_i;
                bt_voice_din <= voice_in_pin;
                voice_clk_pin_o <= bt_voice_clk;
                voice_clk_pin_oe_n <= ~master;
                voice_sync_pin_o <= bt_voice_sync;
                voice_sync_pin_oe_n <= ~master;
                voice_out_pin <= bt_voice_dout;
                bt_voice_clk_in <= master ? bt_voice_clk : voice_clk_pin_i;
                bt_voice_sync_in <= master ? bt_voice_sync : voice_sync_pin_i;
            end
        end
    end
endmodule

// *** spr_pin_router_checker.sv ***
// concurrent checks on the pin router top ports
`timescale 1ns/1ps
module spr_pin_router_checker #(
    parameter STRAP_DELAY_CYCLES = 8,
    parameter SLEEP_MISS_CYCLES = 16
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // pins and section inputs
    input wire host_if_strap,
    input wire wlan_power_enable,
    input wire bluetooth_power_enable,
    input wire sleep_clock_in,
    input wire device_wake_pin_i,
    input wire bt_rts_n,
    input wire bt_voice_dout,
    input wire bt_clk_need,
    input wire wlan_clk_need,
    // design outputs
    input wire link_request_to_send_n_o,
    input wire link_request_to_send_n_oe_n,
    input wire link_clear_to_send_n_o,
    input wire link_clear_to_send_n_oe_n,
    input wire clk_req_pin_o,
    input wire clk_req_pin_oe_n,
    input wire bt_cts_n,
    input wire bt_voice_din,
    input wire bt_three_wire,
    input wire bt_regulator_on,
    input wire bt_reset_n,
    input wire ble_deep_sleep_ok,
    input wire wlan_regulator_on,
    input wire wlan_reset_n,
    input wire wlan_generic_serial_host_mode,
    input wire wlan_strap_done,
    input wire wlan_enable_pulldown_on,
    input wire bt_enable_pulldown_on
);
    int rel_cnt_r = 0, low_cnt_r = 0;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles since release and with the sleep clock low; both saturate
    always @(posedge aclk) begin
        if (!aresetn) rel_cnt_r <= 0;
        else if (rel_cnt_r < 100000) rel_cnt_r <= rel_cnt_r + 1;
        if (!aresetn || sleep_clock_in) low_cnt_r <= 0;
        else if (low_cnt_r < 1000) low_cnt_r <= low_cnt_r + 1;
    end
    a_rts_default: assert property ($past(aresetn) && !bt_three_wire
        |-> link_request_to_send_n_o == $past(bt_rts_n) && !link_request_to_send_n_oe_n)
        else $error("rts pin wrong");
    a_cts_reroute: assert property ($past(aresetn) && bt_three_wire
        |-> link_clear_to_send_n_o == $past(bt_voice_dout) && !link_clear_to_send_n_oe_n
        && bt_voice_din == $past(device_wake_pin_i) && !bt_cts_n)
        else $error("rerouted pins wrong");
    a_wlan_power: assert property ($past(aresetn)
        |-> wlan_regulator_on == $past(wlan_power_enable)
        && (!wlan_reset_n || $past(wlan_power_enable)))
        else $error("wlan power wrong");
    a_bt_power: assert property ($past(aresetn)
        |-> bt_regulator_on == $past(bluetooth_power_enable)
        && bt_reset_n == $past(bluetooth_power_enable))
        else $error("bt power wrong");
    a_clk_request: assert property ($past(aresetn)
        |-> (clk_req_pin_oe_n | clk_req_pin_o) == $past(wlan_clk_need | bt_clk_need))
        else $error("clock request level wrong");
    a_strap_time: assert property ($rose(wlan_strap_done)
        |-> rel_cnt_r == STRAP_DELAY_CYCLES + 1
        && wlan_generic_serial_host_mode == !$past(host_if_strap, 2))
        else $error("strap sample wrong");
    a_strap_hold: assert property (wlan_strap_done
        |=> wlan_strap_done && $stable(wlan_generic_serial_host_mode))
        else $error("latched strap changed");
    a_pulldown_reset: assert property ($past(aresetn) && !$past(aresetn, 2)
        |-> wlan_enable_pulldown_on && bt_enable_pulldown_on && !clk_req_pin_o)
        else $error("pins not at reset value");
    a_sleep_missing: assert property (low_cnt_r > SLEEP_MISS_CYCLES + 3
        |-> !ble_deep_sleep_ok)
        else $error("deep sleep without sleep clock");
endmodule

bind spr_pin_router spr_pin_router_checker #(.STRAP_DELAY_CYCLES(STRAP_DELAY_CYCLES),
    .SLEEP_MISS_CYCLES(SLEEP_MISS_CYCLES)) chk (.*);

// *** spr_host_model.sv ***
// board model: strap resistor and sleep clock
`timescale 1ns/1ps
module spr_host_model (
    // clock
    input wire aclk,
    // board controls
    input wire strap_val,
    input wire sleep_run,
    // pins into the device
    output logic host_if_strap,
    output logic sleep_clock_in
);
    logic [1:0] div_r = 2'h0;
    initial sleep_clock_in = 1'h0;
    // strap resistor level; high is the sdio default
    assign host_if_strap = strap_val;
    // scaled sleep clock, period 8; held low when off
    always @(posedge aclk) begin
        div_r <= div_r + 2'h1;
        if (!sleep_run) sleep_clock_in <= 1'h0;
        else if (div_r == 2'h3) sleep_clock_in <= ~sleep_clock_in;
    end
endmodule

// *** spr_pin_router_bench.sv ***
// self-checking bench for the pin router
`timescale 1ns/1ps
`include "spr_defines.vh"
module spr_pin_router_bench;
    logic aclk = 1'h0, aresetn = 1'h0, strap_val = 1'h0, sleep_run = 1'h0;
    logic host_if_strap, sleep_clock_in;
    // axi4-lite master side; the ready lines stay high
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    // section side and board drive
    logic wlan_power_enable = 1'h1, bluetooth_power_enable = 1'h1, link_serial_in = 1'h1;
    logic voice_in_pin = 1'h0, bt_serial_out = 1'h1, bt_rts_n = 1'h1, host_alert_pin = 1'h0;
    logic host_alert_pin_en = 1'h0, bt_voice_clk = 1'h0, bt_voice_sync = 1'h0, bt_voice_dout = 1'h0;
    logic bt_clk_need = 1'h0, wlan_clk_need = 1'h0, wlan_host_alert = 1'h0;
    logic cts_ext = 1'h1, dwk_ext = 1'h0;
    // design outputs
    logic link_serial_out, link_clear_to_send_n_o, link_clear_to_send_n_oe_n, host_alert_pin_o;
    logic link_request_to_send_n_o, link_request_to_send_n_oe_n, host_alert_pin_oe_n;
    logic device_wake_pin_o, device_wake_pin_oe_n, voice_clk_pin_o, voice_clk_pin_oe_n;
    logic voice_sync_pin_o, voice_sync_pin_oe_n, voice_out_pin, clk_req_pin_o, clk_req_pin_oe_n;
    logic gpio0_pin_o, gpio0_pin_oe_n, bt_serial_in, bt_cts_n, device_wake_pin, bt_voice_clk_in;
    logic bt_voice_sync_in, bt_voice_din, bt_three_wire, bt_voice_master, bt_regulator_on;
    logic bt_reset_n, ble_deep_sleep_ok, wlan_regulator_on, wlan_reset_n, wlan_strap_done;
    logic wlan_generic_serial_host_mode, wlan_enable_pulldown_on, bt_enable_pulldown_on;
    int err_count = 0, checks_done = 0;
    // pad levels; clock request has a board pull-up
    wire link_clear_to_send_n_i = link_clear_to_send_n_oe_n ? cts_ext : link_clear_to_send_n_o;
    wire link_request_to_send_n_i = link_request_to_send_n_oe_n ? 1'h0 : link_request_to_send_n_o;
    wire host_alert_pin_i = host_alert_pin_oe_n ? 1'h0 : host_alert_pin_o;
    wire device_wake_pin_i = device_wake_pin_oe_n ? dwk_ext : device_wake_pin_o;
    wire voice_clk_pin_i = voice_clk_pin_oe_n ? 1'h0 : voice_clk_pin_o;
    wire voice_sync_pin_i = voice_sync_pin_oe_n ? 1'h0 : voice_sync_pin_o;
    wire gpio0_pin_i = gpio0_pin_oe_n ? 1'h0 : gpio0_pin_o;
    wire clk_req_pin_i = clk_req_pin_oe_n ? 1'h1 : clk_req_pin_o;

    spr_pin_router #(.STRAP_DELAY_CYCLES(8), .SLEEP_MISS_CYCLES(16)) dut (.*);
    spr_host_model host (.*);

    // 200 mhz clock
    initial forever #2.5 aclk = ~aclk;

    task automatic chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic st;
        repeat (3) @(posedge aclk);
    endtask

    task automatic rst;
        aresetn <= 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (12) @(posedge aclk);
    endtask

    // write: address and data together, each dropped once taken
    task automatic axw(input logic [3:0] a, logic [31:0] d, logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        chk(s_axi_bresp, er);
    endtask

    task automatic axr(input logic [3:0] a, logic [31:0] ed, logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        finish_test();
    end

    initial begin
        rst();
        chk(wlan_generic_serial_host_mode, 1'h1);
        chk({wlan_enable_pulldown_on, bt_enable_pulldown_on}, 2'h3);
        chk({clk_req_pin_oe_n, clk_req_pin_o}, 2'h0);
        axr(`SPR_ADDR_STATUS, 32'h3, `SPR_RESP_OKAY);
        axr(`SPR_ADDR_CTRL, 32'h0, `SPR_RESP_OKAY);
        strap_val <= 1'h1;
        st();
        chk(wlan_generic_serial_host_mode, 1'h1);
        rst();
        chk(wlan_generic_serial_host_mode, 1'h0);
        $display("test strap done");
        axw(`SPR_ADDR_STATUS, 32'hff, `SPR_RESP_OKAY);
        axr(`SPR_ADDR_STATUS, 32'h2, `SPR_RESP_OKAY);
        axw(4'hc, 32'h1, `SPR_RESP_SLVERR);
        axr(4'hc, 32'h0, `SPR_RESP_SLVERR);
        axw(`SPR_ADDR_CTRL, 32'h30, `SPR_RESP_OKAY);
        st();
        chk({wlan_enable_pulldown_on, bt_enable_pulldown_on}, 2'h0);
        axr(`SPR_ADDR_CTRL, 32'h30, `SPR_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            {bluetooth_power_enable, wlan_power_enable} <= i[1:0];
            st();
            chk({wlan_regulator_on, wlan_reset_n}, {2{i[0]}});
            chk({bt_regulator_on, bt_reset_n}, {2{i[1]}});
        end
        $display("test regs and enables done");
        for (int m = 0; m < 2; m++) begin
            axw(`SPR_ADDR_CTRL, 32'(m + 2), `SPR_RESP_OKAY);
            for (int v = 0; v < 2; v++) begin
                {bt_rts_n, cts_ext, bt_serial_out, bt_voice_clk, bt_voice_sync} <= {5{v[0]}};
                {dwk_ext, bt_voice_dout} <= {2{!v[0]}};
                st();
                chk({link_request_to_send_n_o, link_request_to_send_n_oe_n}, {v[0], 1'h0});
                chk({link_clear_to_send_n_o, link_clear_to_send_n_oe_n}, m ? {!v[0], 1'h0} : 2'h3);
                chk(m ? host_alert_pin_o : bt_cts_n, v[0]);
                chk(m ? bt_voice_din : device_wake_pin, !v[0]);
                chk({bt_three_wire, link_serial_out}, {m[0], v[0]});
                chk({voice_clk_pin_oe_n, voice_sync_pin_oe_n}, {2{m[0]}});
            end
        end
        $display("test routing done");
        for (int p = 0; p < 2; p++) begin
            axw(`SPR_ADDR_CTRL, 32'(p * 8 + 4), `SPR_RESP_OKAY);
            for (int n = 0; n < 4; n++) begin
                {bt_clk_need, wlan_clk_need, wlan_host_alert} <= {n[1], n[0], n[0]};
                st();
                chk(clk_req_pin_i, n != 0);
                chk(clk_req_pin_oe_n, p ? 1'h0 : n != 0);
                chk({gpio0_pin_oe_n, gpio0_pin_o}, {1'h0, n[0]});
            end
        end
        sleep_run <= 1'h1;
        repeat (40) @(posedge aclk);
        chk(ble_deep_sleep_ok, 1'h1);
        sleep_run <= 1'h0;
        repeat (40) @(posedge aclk);
        chk(ble_deep_sleep_ok, 1'h0);
        $display("test clock request and sleep done");
        finish_test();
    end
endmodule
